// [src/hbp_host_port.v]
// Host bus register port of the temperature measurement board
`timescale 1ns/1ps
`default_nettype none
`include "hbp_consts.vh"

module hbp_host_port (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        ce,
  // Host system bus
  input  wire [23:0] bus_addr,
  input  wire [15:0] bus_data_in,
  input  wire        mem_rd_n,
  input  wire        mem_wr_n,
  input  wire        io_rd_n,
  input  wire        io_wr_n,
  input  wire        byte_high_en_n,
  output reg  [15:0] bus_data_out,
  output reg         bus_data_oe,
  output reg         xfer_ack_n,
  // Jumpers and switches
  input  wire [23:0] base_addr,
  input  wire        io_space_sel,
  input  wire [2:0]  acknowledge_delay_select,
  input  wire        calib_switch,
  input  wire        unit_fahrenheit,
  input  wire        voltage_input_mode,
  // On-board processor side
  input  wire        cmd_accept,
  input  wire        result_load,
  input  wire        result_raw_sign,
  input  wire [11:0] result_raw_mag,
  input  wire        result_lin_sign,
  input  wire [11:0] result_lin_mag,
  input  wire [3:0]  result_err_code,
  input  wire [2:0]  result_chan,
  input  wire        selftest_done,
  input  wire        selftest_pass,
  output reg  [7:0]  conversion_command,
  output reg         cmd_pending,
  output reg         cmd_written,
  output reg         result_taken,
  output reg         calib_mode,
  output reg         board_ok
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_ACK  = 2'h2;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         data_ready_r;
  reg         is_read_r;
  reg         test_seen_r;
  reg         test_fail_r;

  wire        rd_act;
  wire        wr_act;
  wire        hit;
  wire        start;
  wire        lo_en;
  wire        hi_en;
  wire [1:0]  lo_ofs;
  wire [1:0]  hi_ofs;
  wire        cmd_wr_lo;
  wire        cmd_wr_hi;
  wire        cmd_wr;
  wire        res_rd;
  wire        ack_done;
  wire [15:0] res_word;
  wire [3:0]  res_err;
  wire [2:0]  res_chan;
  wire        res_unit;
  wire [3:0]  err_shown;
  wire [7:0]  ready_byte;
  wire [7:0]  status_byte;

  // Strobe family picked by the space jumper
  assign rd_act = io_space_sel ? ~io_rd_n : ~mem_rd_n;
  assign wr_act = io_space_sel ? ~io_wr_n : ~mem_wr_n;

  // I/O space decodes 16 address bits, memory space the full 24
  function addr_match;
    input [23:0] a;
    input [23:0] b;
    input        io;
    begin
      if (io)
        addr_match = (a[15:2] == b[15:2]);
      else
        addr_match = (a[23:2] == b[23:2]);
    end
  endfunction

  assign hit = addr_match(bus_addr, base_addr, io_space_sel);

  assign start = (state_r == ST_IDLE) && (rd_act || wr_act) && hit;

  // Byte lanes: 8-bit cycles use the low lane, 16-bit cycles carry the odd byte high
  assign lo_en  = byte_high_en_n | ~bus_addr[0];
  assign hi_en  = ~byte_high_en_n;
  assign lo_ofs = bus_addr[1:0];
  assign hi_ofs = {bus_addr[1], 1'b1};

  assign cmd_wr_lo = lo_en && (lo_ofs == `HBP_OFS_CMD_STAT);
  assign cmd_wr_hi = hi_en && (hi_ofs == `HBP_OFS_CMD_STAT);
  assign cmd_wr    = start && wr_act && (cmd_wr_lo || cmd_wr_hi);
  assign res_rd    = start && rd_act && ((lo_en && lo_ofs[1]) || (hi_en && hi_ofs[1]));

  // Live faults outrank the code latched with the last result
  assign err_shown = test_fail_r   ? `HBP_ERR_BOARD_FAIL :
                     !test_seen_r  ? `HBP_ERR_NOT_READY :
                     calib_switch  ? `HBP_ERR_CAL :
                     res_err;

  assign ready_byte = {6'h00, data_ready_r, cmd_pending};
  assign status_byte = {err_shown, res_unit, res_chan};

  function [7:0] read_byte;
    input [1:0]  ofs;
    input [7:0]  rdy;
    input [7:0]  stat;
    input [15:0] res;
    begin
      case (ofs)
        `HBP_OFS_READY:    read_byte = rdy;
        `HBP_OFS_CMD_STAT: read_byte = stat;
        `HBP_OFS_RES_LO:   read_byte = res[7:0];
        `HBP_OFS_RES_HI:   read_byte = res[15:8];
        default:           read_byte = 8'h00;
      endcase
    end
  endfunction

  hbp_ack_timer u_ack_timer (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .start     (start),
    .delay_sel (acknowledge_delay_select),
    .done      (ack_done)
  );

  hbp_result_store u_result_store (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .load     (result_load),
    .use_raw  (voltage_input_mode),
    .sign_mag (conversion_command[`HBP_CMD_CODING_BIT]),
    .raw_sign (result_raw_sign),
    .raw_mag  (result_raw_mag),
    .lin_sign (result_lin_sign),
    .lin_mag  (result_lin_mag),
    .err_code (result_err_code),
    .chan     (result_chan),
    .unit_f   (unit_fahrenheit),
    .result   (res_word),
    .err      (res_err),
    .chan_q   (res_chan),
    .unit_q   (res_unit)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start)
          state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (ack_done)
          state_nxt = ST_ACK;
      end
      ST_ACK: begin
        // Hold the acknowledge until the host lets go of the strobe
        if (!(rd_act || wr_act))
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Bus cycle sequencing and answer
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      is_read_r    <= 1'b0;
      bus_data_out <= 16'h0000;
      bus_data_oe  <= 1'b0;
      xfer_ack_n   <= 1'b1;
    end else if (ce) begin
      state_r <= state_nxt;
      if (start) begin
        is_read_r    <= rd_act;
        // Snapshot taken before the read side effects land
        bus_data_out <= {hi_en ? read_byte(hi_ofs, ready_byte, status_byte, res_word) : 8'h00,
                         lo_en ? read_byte(lo_ofs, ready_byte, status_byte, res_word) : 8'h00};
      end
      if (state_r == ST_WAIT && ack_done) begin
        xfer_ack_n  <= 1'b0;
        bus_data_oe <= is_read_r;
      end else if (state_nxt == ST_IDLE) begin
        xfer_ack_n  <= 1'b1;
        bus_data_oe <= 1'b0;
      end
    end
  end

  // Command register; writes at other offsets fall through untouched
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conversion_command <= `HBP_CMD_RST;
      cmd_written        <= 1'b0;
      calib_mode         <= 1'b0;
    end else if (ce) begin
      cmd_written <= cmd_wr;
      if (cmd_wr) begin
        conversion_command <= cmd_wr_lo ? bus_data_in[7:0] : bus_data_in[15:8];
        calib_mode         <= cmd_wr_lo ? bus_data_in[`HBP_CMD_CAL_BIT]
                                        : bus_data_in[8 + `HBP_CMD_CAL_BIT];
      end
    end
  end

  // Handshake flags; a set in the same cycle as its clear wins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_pending  <= 1'b0;
      data_ready_r <= 1'b0;
      result_taken <= 1'b0;
    end else if (ce) begin
      result_taken <= res_rd;
      if (cmd_wr)
        cmd_pending <= 1'b1;
      else if (cmd_accept)
        cmd_pending <= 1'b0;
      if (result_load)
        data_ready_r <= 1'b1;
      else if (cmd_wr || res_rd)
        data_ready_r <= 1'b0;
    end
  end

  // Self-test outcome is caught once, when the processor reports it done
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      test_seen_r <= 1'b0;
      test_fail_r <= 1'b0;
      board_ok    <= 1'b0;
    end else if (ce) begin
      if (selftest_done && !test_seen_r) begin
        test_seen_r <= 1'b1;
        test_fail_r <= ~selftest_pass;
        board_ok    <= selftest_pass;
      end
    end
  end

endmodule // hbp_host_port
`default_nettype wire

// [src/hbp_consts.vh]
// Constants for the temperature board host register port
`ifndef HBP_CONSTS_VH
`define HBP_CONSTS_VH

`define HBP_OFS_READY        2'h0
`define HBP_OFS_CMD_STAT     2'h1
`define HBP_OFS_RES_LO       2'h2
`define HBP_OFS_RES_HI       2'h3

`define HBP_RDY_CMD_PEND_BIT 0
`define HBP_RDY_DATA_BIT     1

`define HBP_CMD_CHAN_MSB     2
`define HBP_CMD_CHAN_LSB     0
`define HBP_CMD_SCAN_BIT     4
`define HBP_CMD_CODING_BIT   5
`define HBP_CMD_GAIN_BIT     6
`define HBP_CMD_CAL_BIT      7

`define HBP_STAT_ERR_MSB     7
`define HBP_STAT_ERR_LSB     4
`define HBP_STAT_UNIT_BIT    3
`define HBP_STAT_CHAN_MSB    2
`define HBP_STAT_CHAN_LSB    0

`define HBP_ERR_NONE         4'h0
`define HBP_ERR_CAL          4'h8
`define HBP_ERR_RANGE        4'h9
`define HBP_ERR_OPEN         4'ha
`define HBP_ERR_NOT_READY    4'hb
`define HBP_ERR_JUNC_RANGE    4'hc
`define HBP_ERR_JUNC_AND_DATA 4'hd
`define HBP_ERR_JUNC_OR_OPEN  4'he
`define HBP_ERR_BOARD_FAIL   4'hf

`define HBP_CMD_RST          8'h00
`define HBP_RESULT_RST       16'h0000
`define HBP_CHAN_RST         3'h0

`define HBP_CLK_PERIOD_NS    10
`define HBP_ACK_STEP_NS      100
`define HBP_ACK_STEP_CYC     (`HBP_ACK_STEP_NS / `HBP_CLK_PERIOD_NS)

`endif

// [src/hbp_ack_timer.v]
// Transfer acknowledge delay counter
`timescale 1ns/1ps
`default_nettype none
`include "hbp_consts.vh"

module hbp_ack_timer (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       ce,
  input  wire       start,
  input  wire [2:0] delay_sel,
  output reg        done
);

  reg  [6:0] cnt_r;
  reg        run_r;
  wire [6:0]  load_val;
  wire [31:0] load_full;

  // Step n of the jumper gives (n+1) * 100 ns; two cycles go to the done and acknowledge flops
  assign load_full = ({29'h0, delay_sel} + 32'h1) * `HBP_ACK_STEP_CYC - 32'h2;
  assign load_val  = load_full[6:0];

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 7'h00;
      run_r <= 1'b0;
      done  <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= load_val;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == 7'h00) begin
          run_r <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 7'h01;
        end
      end
    end
  end

endmodule // hbp_ack_timer
`default_nettype wire

// [src/hbp_result_store.v]
// Result and status holding registers with output coding
`timescale 1ns/1ps
`default_nettype none
`include "hbp_consts.vh"

module hbp_result_store (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        ce,
  input  wire        load,
  input  wire        use_raw,
  input  wire        sign_mag,
  input  wire        raw_sign,
  input  wire [11:0] raw_mag,
  input  wire        lin_sign,
  input  wire [11:0] lin_mag,
  input  wire [3:0]  err_code,
  input  wire [2:0]  chan,
  input  wire        unit_f,
  output reg  [15:0] result,
  output reg  [3:0]  err,
  output reg  [2:0]  chan_q,
  output reg         unit_q
);

  wire        src_sign;
  wire [11:0] src_mag;
  wire [12:0] twos;

  assign src_sign = use_raw ? raw_sign : lin_sign;
  assign src_mag  = use_raw ? raw_mag : lin_mag;
  assign twos     = src_sign ? (13'h0000 - {1'b0, src_mag}) : {1'b0, src_mag};

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result <= `HBP_RESULT_RST;
      err    <= `HBP_ERR_NONE;
      chan_q <= `HBP_CHAN_RST;
      unit_q <= 1'b0;
    end else if (ce && load) begin
      if (sign_mag)
        result <= {{4{src_sign}}, src_mag};
      else
        result <= {{4{twos[12]}}, twos[11:0]};
      err    <= err_code;
      chan_q <= chan;
      unit_q <= unit_f;
    end
  end

endmodule // hbp_result_store
`default_nettype wire

// [testbench/hbp_props.sv]
// Assertions on the host register port
`timescale 1ns/1ps
`default_nettype none
module hbp_props (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       io_space_sel,
  input wire logic       mem_rd_n,
  input wire logic       mem_wr_n,
  input wire logic       io_rd_n,
  input wire logic       io_wr_n,
  input wire logic [2:0] acknowledge_delay_select,
  input wire logic       xfer_ack_n,
  input wire logic       bus_data_oe,
  input wire logic       cmd_accept,
  input wire logic       cmd_pending,
  input wire logic       cmd_written,
  input wire logic       result_taken,
  input wire logic [7:0] conversion_command,
  input wire logic       calib_mode,
  input wire logic       selftest_done,
  input wire logic       board_ok
);
  logic       stb;
  logic       rd_stb;
  logic [7:0] cnt_r;
  assign stb = io_space_sel ? !(io_rd_n && io_wr_n) : !(mem_rd_n && mem_wr_n);
  assign rd_stb = io_space_sel ? !io_rd_n : !mem_rd_n;
  // Cycles since the strobe came up; saturates so a hung cycle cannot wrap
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      cnt_r <= 8'h00;
    else if (!stb)
      cnt_r <= 8'h00;
    else if (cnt_r != 8'hff)
      cnt_r <= cnt_r + 8'h01;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence ack_start; $fell(xfer_ack_n); endsequence
  sequence ack_done; !xfer_ack_n && !stb; endsequence
  ack_delay_a: assert property (ack_start |-> cnt_r == 8'h0a * {5'h00, acknowledge_delay_select} + 8'h0b)
    else $error("ack delay off");
  ack_release_a: assert property (ack_done |=> xfer_ack_n) else $error("ack held");
  ack_strobe_a: assert property (!stb && xfer_ack_n |=> xfer_ack_n) else $error("ack without strobe");
  oe_ack_a: assert property (bus_data_oe |-> !xfer_ack_n) else $error("oe without ack");
  read_oe_a: assert property (!xfer_ack_n && stb |-> bus_data_oe == rd_stb) else $error("oe not matching cycle");
  accept_clr_a: assert property (cmd_accept && !stb |=> !cmd_pending) else $error("pending stuck");
  written_once_a: assert property (cmd_written |=> !cmd_written) else $error("long write pulse");
  written_pend_a: assert property (cmd_written |-> cmd_pending) else $error("pending not set");
  taken_once_a: assert property (result_taken |=> !result_taken) else $error("long take pulse");
  calib_bit_a: assert property (cmd_written |-> calib_mode == conversion_command[7]) else $error("calib");
  board_ok_a: assert property (board_ok |-> $past(selftest_done)) else $error("early board ok");
endmodule // hbp_props
bind hbp_host_port hbp_props i_hbp_props (.clk_sys(clk_sys), .rst(rst), .io_space_sel(io_space_sel),
  .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
  .acknowledge_delay_select(acknowledge_delay_select), .xfer_ack_n(xfer_ack_n), .bus_data_oe(bus_data_oe),
  .cmd_accept(cmd_accept), .cmd_pending(cmd_pending), .cmd_written(cmd_written), .result_taken(result_taken),
  .conversion_command(conversion_command), .calib_mode(calib_mode), .selftest_done(selftest_done),
  .board_ok(board_ok));
`default_nettype wire

// [testbench/hbp_host_model.sv]
// Host bus master model
`timescale 1ns/1ps
`default_nettype none
module hbp_host_model (
  input  wire logic        clk_sys,
  input  wire logic        io_sel,
  input  wire logic        xfer_ack_n,
  input  wire logic [15:0] bus_data_out,
  output var  logic [23:0] bus_addr,
  output var  logic [15:0] bus_data_in,
  output var  logic [3:0]  stb_n,
  output var  logic        byte_high_en_n
);
  initial begin
    bus_addr = 24'h000000;
    bus_data_in = 16'h0000;
    stb_n = 4'hf;
    byte_high_en_n = 1'b1;
  end
  // Strobe order: io_rd, io_wr, mem_rd, mem_wr; ok stays low if no ack
  task automatic xfer(input logic wr, input logic [23:0] a, input logic [15:0] d, input logic bhe_n,
                      output logic [15:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    q = 16'h0000;
    @(negedge clk_sys);
    bus_addr = a;
    byte_high_en_n = bhe_n;
    if (wr)
      bus_data_in = d;
    stb_n = ~{io_sel & !wr, io_sel & wr, !io_sel & !wr, !io_sel & wr};
    while (!ok && n < 120) begin
      @(posedge clk_sys);
      n++;
      if (xfer_ack_n === 1'b0) begin
        ok = 1'b1;
        q = bus_data_out;
      end
    end
    @(negedge clk_sys);
    stb_n = 4'hf;
    // Released lines must not keep showing the old value
    bus_data_in = ~bus_data_in;
    bus_addr = ~a;
    @(negedge clk_sys);
  endtask
endmodule // hbp_host_model
`default_nettype wire

// [testbench/hbp_host_port_tb_top.sv]
// Self-checking bench for the host register port
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port_tb_top;
  logic        clk_sys = 0, rst = 1, io_sel = 0, cal_sw = 0, unit_f = 0, volt = 0, acc = 0, ld = 0;
  logic        st_done = 0, st_pass = 0, ls = 0, ok;
  logic [2:0]  dly = 0;
  logic [3:0]  rerr = 0;
  logic [11:0] lm = 0, rm = 0;
  logic [15:0] q, dout, din;
  logic [23:0] base = 24'h123450, addr;
  logic [3:0]  stb_n;
  logic [7:0]  cmd;
  logic        bhe_n, oe, ack_n, pend, wrp, tkn, calm, bok;
  int          err_count = 0, num_checks = 0, cyc = 0, n_wr = 0, n_tk = 0;
  always #5 clk_sys = ~clk_sys;
  hbp_host_model i_hbp_host_model (.clk_sys(clk_sys), .io_sel(io_sel), .xfer_ack_n(ack_n), .bus_data_out(dout),
    .bus_addr(addr), .bus_data_in(din), .stb_n(stb_n), .byte_high_en_n(bhe_n));
  hbp_host_port i_hbp_host_port (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .bus_addr(addr), .bus_data_in(din),
    .mem_rd_n(stb_n[1]), .mem_wr_n(stb_n[0]), .io_rd_n(stb_n[3]), .io_wr_n(stb_n[2]), .byte_high_en_n(bhe_n),
    .bus_data_out(dout), .bus_data_oe(oe), .xfer_ack_n(ack_n), .base_addr(base), .io_space_sel(io_sel),
    .acknowledge_delay_select(dly), .calib_switch(cal_sw), .unit_fahrenheit(unit_f), .voltage_input_mode(volt),
    .cmd_accept(acc), .result_load(ld), .result_raw_sign(1'b0), .result_raw_mag(rm), .result_lin_sign(ls),
    .result_lin_mag(lm), .result_err_code(rerr), .result_chan(3'h5), .selftest_done(st_done),
    .selftest_pass(st_pass), .conversion_command(cmd), .cmd_pending(pend), .cmd_written(wrp),
    .result_taken(tkn), .calib_mode(calm), .board_ok(bok));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [1:0] o, input logic b, input logic [15:0] e);
    i_hbp_host_model.xfer(1'b0, base + {22'h0, o}, 16'h0000, b, q, ok);
    chk("read data", e, q);
  endtask
  task automatic wr(input logic [1:0] o, input logic [15:0] d);
    i_hbp_host_model.xfer(1'b1, base + {22'h0, o}, d, 1'b1, q, ok);
  endtask
  task automatic pulse(input logic load, input logic [3:0] e);
    @(negedge clk_sys);
    rerr = e;
    acc = !load;
    ld = load;
    @(negedge clk_sys);
    {acc, ld} = 2'b00;
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  always @(posedge clk_sys) begin
    if (wrp === 1'b1)
      n_wr++;
    if (tkn === 1'b1)
      n_tk++;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 0;
    rd(2'h1, 1'b1, 16'h00b0);
    st_done = 1;
    st_pass = 1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      dly = i[2:0];
      rd(2'h0, 1'b1, 16'h0000);
    end
    chk("board ok", 16'h0001, {15'h0, bok});
    wr(2'h1, 16'h0075);
    chk("command", 16'h0075, {8'h00, cmd});
    rd(2'h0, 1'b1, 16'h0001);
    wr(2'h0, 16'h00aa);
    wr(2'h3, 16'h00bb);
    chk("command", 16'h0075, {8'h00, cmd});
    pulse(1'b0, 4'h0);
    rd(2'h0, 1'b1, 16'h0000);
    i_hbp_host_model.xfer(1'b1, base, 16'h35aa, 1'b0, q, ok);
    chk("command", 16'h0035, {8'h00, cmd});
    pulse(1'b0, 4'h0);
    lm = 12'h123;
    ls = 1;
    unit_f = 1;
    pulse(1'b1, 4'h9);
    rd(2'h0, 1'b1, 16'h0002);
    rd(2'h1, 1'b1, 16'h009d);
    rd(2'h2, 1'b0, 16'hf123);
    rd(2'h3, 1'b0, 16'hf100);
    rd(2'h0, 1'b1, 16'h0000);
    wr(2'h1, 16'h0005);
    pulse(1'b0, 4'h0);
    pulse(1'b1, 4'h0);
    rd(2'h2, 1'b0, 16'hfedd);
    pulse(1'b1, 4'h0);
    wr(2'h1, 16'h0005);
    rd(2'h0, 1'b1, 16'h0001);
    pulse(1'b0, 4'h0);
    volt = 1;
    rm = 12'h456;
    pulse(1'b1, 4'h0);
    rd(2'h3, 1'b1, 16'h0004);
    volt = 0;
    for (int i = 8; i < 16; i++) begin
      pulse(1'b1, i[3:0]);
      rd(2'h1, 1'b1, {8'h00, i[3:0], 4'hd});
    end
    cal_sw = 1;
    rd(2'h1, 1'b1, 16'h008d);
    cal_sw = 0;
    wr(2'h1, 16'h0080);
    chk("calib", 16'h0001, {15'h0, calm});
    pulse(1'b0, 4'h0);
    i_hbp_host_model.xfer(1'b0, base + 24'h4, 16'h0000, 1'b1, q, ok);
    chk("unmapped ack", 16'h0000, {15'h0, ok});
    io_sel = 1;
    rd(2'h1, 1'b1, 16'h00fd);
    chk("write pulses", 16'h0005, n_wr[15:0]);
    chk("take pulses", 16'h0004, n_tk[15:0]);
    @(negedge clk_sys);
    rst = 1;
    st_done = 0;
    st_pass = 0;
    io_sel = 0;
    @(negedge clk_sys);
    rst = 0;
    st_done = 1;
    rd(2'h1, 1'b1, 16'h00f0);
    chk("board ok", 16'h0000, {15'h0, bok});
    report_and_stop();
  end
endmodule // hbp_host_port_tb_top
`default_nettype wire
